// ---- include/ias_pkg.sv ----
package ias_pkg;

    // device address on the two-wire bus, upper seven bits of the first byte
    localparam logic [6:0] IAS_SLAVE_ADDR = 7'h62;
    localparam logic [7:0] IAS_PTR_RESET = 8'h00;
    localparam logic [3:0] IAS_BYTE_BITS = 4'h8;
    localparam logic IAS_DIR_READ = 1'b1;

    // register map offsets
    localparam logic [7:0] IAS_OFS_IRQ_FLAGS_PRIMARY = 8'h00;
    localparam logic [7:0] IAS_OFS_IRQ_FLAGS_SECONDARY = 8'h01;
    localparam logic [7:0] IAS_OFS_IRQ_MASK_PRIMARY = 8'h02;
    localparam logic [7:0] IAS_OFS_IRQ_MASK_SECONDARY = 8'h03;
    localparam logic [7:0] IAS_OFS_QUEUE_WRITE_INDEX = 8'h04;
    localparam logic [7:0] IAS_OFS_QUEUE_READ_INDEX = 8'h05;
    localparam logic [7:0] IAS_OFS_OVERFLOW_TALLY = 8'h06;
    localparam logic [7:0] IAS_OFS_QUEUE_FILL_LEVEL = 8'h07;
    localparam logic [7:0] IAS_OFS_QUEUE_READ_PORT = 8'h08;
    localparam logic [7:0] IAS_OFS_QUEUE_ALMOST_FULL_LEVEL = 8'h09;
    localparam logic [7:0] IAS_OFS_QUEUE_OPTIONS = 8'h0a;
    localparam logic [7:0] IAS_OFS_SYSTEM_CONTROL = 8'h0d;
    localparam logic [7:0] IAS_OFS_SAMPLE_SYNC_CONTROL = 8'h10;
    localparam logic [7:0] IAS_OFS_OPTICAL_CONFIG_ONE = 8'h11;
    localparam logic [7:0] IAS_OFS_OPTICAL_CONFIG_TWO = 8'h12;
    localparam logic [7:0] IAS_OFS_OPTICAL_CONFIG_THREE = 8'h13;
    localparam logic [7:0] IAS_OFS_PROXIMITY_THRESHOLD = 8'h14;
    localparam logic [7:0] IAS_OFS_PHOTODIODE_BIAS = 8'h15;
    localparam logic [7:0] IAS_OFS_SPIKE_FILTER_CONFIG = 8'h16;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_AACK = 7'h04,
        ST_RX   = 7'h08,
        ST_RACK = 7'h10,
        ST_TX   = 7'h20,
        ST_TACK = 7'h40
    } ias_state_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
    } ias_bus_ev_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic wr;
        logic rd;
    } ias_reg_req_t;

endpackage

// ---- hw/ias_cond_detect.sv ----
`timescale 1ns/1ns
`default_nettype none

module ias_cond_detect
    import ias_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // bus lines
    input wire logic scl_i,
    input wire logic sda_i,
    // decoded bus events, valid one cycle
    output var ias_bus_ev_t ev
);

    logic scl_q;
    logic sda_q;
    logic scl_p;
    logic sda_p;

    // idle bus is high on both lines, so no false start leaves reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            scl_p <= scl_q;
            sda_p <= sda_q;
        end
    end

    always_comb begin
        ev.start = scl_p & scl_q & sda_p & ~sda_q;
        ev.stop = scl_p & scl_q & ~sda_p & sda_q;
        ev.scl_rise = ~scl_p & scl_q;
        ev.scl_fall = scl_p & ~scl_q;
        ev.sda = sda_q;
    end

    // a stop on the pins must reach the frame logic two edges later, whatever state it is in
    property p_stop_seen;
        @(posedge clk) disable iff (!reset_n)
        ($past(reset_n, 2) && $past(reset_n) && $past(scl_i, 2) && $past(scl_i)
            && !$past(sda_i, 2) && $past(sda_i)) |-> ev.stop;
    endproperty
    a_stop_seen: assert property (p_stop_seen) else $error("stop on pins not decoded"); // RL17

endmodule

`default_nettype wire

// ---- hw/ias_slave.sv ----
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// (RL1) Ack each received write byte by holding data low through the ninth clock.
// (RL2) Master treats a missing ack as failure and retries.
// (RL3) Master acks read bytes it continues past, nacks the last, then stops.
// (RL4) Write frame: start, address with write bit, pointer byte, data bytes, stop.
// (RL5) Acknowledge own address with write bit in the ninth clock.
// (RL6) First byte after a write address loads the register pointer and is acked.
// (RL7) Later write bytes go to the pointed register, are acked, pointer advances.
// (RL8) Writes to the queue read port do not advance the pointer.
// (RL9) Acknowledge own address with read bit, then start sending data.
// (RL10) Start followed directly by a read address clears the pointer to zero.
// (RL11) Each sent bit is valid on data at the rising clock edge.
// (RL12) Pointer advances by one after every sent byte.
// (RL13) Pointer stays put on the queue read port while reading.
// (RL14) Stop accepted after any read byte; a later plain read starts at zero.
// (RL15) Write address, pointer byte, repeated start, read address reads that register.
// (RL16) Respond only when upper seven bits match the device address.
// (RL17) Stop honoured anywhere; master never puts stop in the start high period.
// (RL18) Release data during the ack slot after each sent byte.
module ias_slave
    import ias_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = IAS_SLAVE_ADDR,
    parameter logic [7:0] STREAM_REG = IAS_OFS_QUEUE_READ_PORT
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // two-wire bus, data is open drain
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // register file access
    output logic [7:0] reg_ptr,
    output ias_reg_req_t reg_req,
    input wire logic [7:0] reg_rd_data
);

    ias_bus_ev_t ev;
    ias_state_t st_q;
    logic [3:0] cnt_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic [7:0] ptr_q;
    logic rw_q;
    logic first_q;
    logic preset_q;
    logic ack_q;
    logic sda_oe_q;
    logic sda_o_q;
    ias_reg_req_t req_q;
    logic byte_done;
    logic addr_match;
    logic load_tx;
    logic in_ack;
    logic [7:0] ptr_next;

    ias_cond_detect u_det (
        .clk(clk),
        .reset_n(reset_n),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .ev(ev)
    );

    // eighth bit has been clocked in or out and its clock has ended
    assign byte_done = ev.scl_fall && (cnt_q == IAS_BYTE_BITS);
    assign addr_match = (shift_q[7:1] == SLAVE_ADDR); // RL16
    assign in_ack = (st_q == ST_AACK) || (st_q == ST_RACK);
    // next byte is fetched when the ack slot ends, so the source can pop in time
    assign load_tx = ev.scl_fall
        && (((st_q == ST_AACK) && rw_q) || ((st_q == ST_TACK) && ack_q));
    // the stream register parks the pointer so a burst drains it
    assign ptr_next = (ptr_q == STREAM_REG) ? ptr_q : 8'(ptr_q + 8'h01); // RL8 RL13

    // frame sequencing
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= ST_IDLE;
        end else if (ev.stop) begin
            st_q <= ST_IDLE; // RL17
        end else if (ev.start) begin
            st_q <= ST_ADDR;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    st_q <= ST_IDLE;
                end
                ST_ADDR: begin
                    if (byte_done) begin
                        st_q <= addr_match ? ST_AACK : ST_IDLE; // RL16
                    end
                end
                ST_AACK: begin
                    if (ev.scl_fall) begin
                        st_q <= rw_q ? ST_TX : ST_RX; // RL9
                    end
                end
                ST_RX: begin
                    if (byte_done) begin
                        st_q <= ST_RACK;
                    end
                end
                ST_RACK: begin
                    if (ev.scl_fall) begin
                        st_q <= ST_RX;
                    end
                end
                ST_TX: begin
                    if (byte_done) begin
                        st_q <= ST_TACK;
                    end
                end
                ST_TACK: begin
                    // a nack ends sending; the device then waits for stop
                    if (ev.scl_fall) begin
                        st_q <= ack_q ? ST_TX : ST_IDLE; // RL3
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // bit counter, counts rising clock edges within a byte
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 4'h0;
        end else if (ev.start || ev.stop) begin
            cnt_q <= 4'h0;
        end else if (ev.scl_fall && (in_ack || (st_q == ST_TACK))) begin
            cnt_q <= 4'h0;
        end else if (ev.scl_rise
            && ((st_q == ST_ADDR) || (st_q == ST_RX) || (st_q == ST_TX))) begin
            cnt_q <= 4'(cnt_q + 4'h1);
        end
    end

    // receive shifter, msb first, sampled while the clock is high
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_q <= 8'h00;
        end else if (ev.scl_rise && ((st_q == ST_ADDR) || (st_q == ST_RX))) begin
            shift_q <= {shift_q[6:0], ev.sda};
        end
    end

    // direction bit and master ack capture
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rw_q <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            if ((st_q == ST_ADDR) && byte_done && addr_match) begin
                rw_q <= shift_q[0];
            end
            if ((st_q == ST_TACK) && ev.scl_rise) begin
                ack_q <= !ev.sda; // RL3
            end
        end
    end

    // transmit shifter, top bit is the bit on the wire
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_q <= 8'h00;
        end else if (load_tx) begin
            tx_q <= reg_rd_data;
        end else if (ev.scl_fall && (st_q == ST_TX) && !byte_done) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // data line drive; changes only after a falling clock so it is stable high
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sda_oe_q <= 1'b0;
        end else if (ev.start || ev.stop) begin
            sda_oe_q <= 1'b0; // RL17
        end else if (byte_done && (st_q == ST_ADDR)) begin
            sda_oe_q <= addr_match; // RL5 RL9 RL16
        end else if (byte_done && (st_q == ST_RX)) begin
            sda_oe_q <= 1'b1; // RL1
        end else if (byte_done && (st_q == ST_TX)) begin
            sda_oe_q <= 1'b0; // RL18
        end else if (load_tx) begin
            sda_oe_q <= !reg_rd_data[7]; // RL11
        end else if (ev.scl_fall && (st_q == ST_TX)) begin
            sda_oe_q <= !tx_q[6]; // RL11
        end else if (ev.scl_fall && (in_ack || (st_q == ST_TACK))) begin
            sda_oe_q <= 1'b0;
        end
    end

    // open drain: the driven level is always low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sda_o_q <= 1'b0;
        end else begin
            sda_o_q <= 1'b0;
        end
    end

    // register pointer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ptr_q <= IAS_PTR_RESET;
            first_q <= 1'b0;
        end else if ((st_q == ST_ADDR) && byte_done && addr_match) begin
            first_q <= (shift_q[0] != IAS_DIR_READ);
            if ((shift_q[0] == IAS_DIR_READ) && !preset_q) begin
                ptr_q <= IAS_PTR_RESET; // RL10 RL14
            end
        end else if ((st_q == ST_RX) && byte_done) begin
            first_q <= 1'b0;
            if (first_q) begin
                ptr_q <= shift_q; // RL6
            end else begin
                ptr_q <= ptr_next; // RL7 RL8
            end
        end else if ((st_q == ST_TX) && byte_done) begin
            ptr_q <= ptr_next; // RL12 RL13
        end
    end

    // a pointer byte survives a repeated start, never a stop
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            preset_q <= 1'b0;
        end else if (ev.stop) begin
            preset_q <= 1'b0; // RL14
        end else if ((st_q == ST_ADDR) && byte_done && addr_match
            && (shift_q[0] == IAS_DIR_READ)) begin
            preset_q <= 1'b0;
        end else if ((st_q == ST_RX) && byte_done && first_q) begin
            preset_q <= 1'b1; // RL15
        end
    end

    // register file strobes, one cycle each
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            req_q <= '0;
        end else begin
            req_q.wr <= 1'b0;
            req_q.rd <= 1'b0;
            if ((st_q == ST_RX) && byte_done && !first_q) begin
                req_q.addr <= ptr_q; // RL7
                req_q.data <= shift_q;
                req_q.wr <= 1'b1;
            end else if (load_tx) begin
                req_q.addr <= ptr_q;
                req_q.data <= reg_rd_data;
                req_q.rd <= 1'b1;
            end
        end
    end

    assign sda_o = sda_o_q;
    assign sda_oe = sda_oe_q;
    assign reg_ptr = ptr_q;
    assign reg_req = req_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_addr_ack;
        (st_q == ST_ADDR && byte_done && addr_match) |=> sda_oe_q && st_q == ST_AACK;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("own address not acked"); // RL5

    property p_addr_ignore;
        (st_q == ST_ADDR && byte_done && !addr_match) |=> !sda_oe_q && st_q == ST_IDLE;
    endproperty
    a_addr_ignore: assert property (p_addr_ignore) else $error("foreign address acked"); // RL16

    property p_data_ack;
        (st_q == ST_RX && byte_done) |=> sda_oe_q && st_q == ST_RACK;
    endproperty
    a_data_ack: assert property (p_data_ack) else $error("write byte not acked"); // RL1

    property p_ack_held;
        (in_ack && ev.scl_rise) |-> sda_oe_q ##1 sda_oe_q;
    endproperty
    a_ack_held: assert property (p_ack_held) else $error("ack dropped in ninth clock"); // RL1

    property p_ptr_load;
        (st_q == ST_RX && byte_done && first_q) |=> ptr_q == $past(shift_q) && preset_q;
    endproperty
    a_ptr_load: assert property (p_ptr_load) else $error("pointer byte not loaded"); // RL6

    property p_write_step;
        (st_q == ST_RX && byte_done && !first_q) |=> req_q.wr && req_q.addr == $past(ptr_q)
            && req_q.data == $past(shift_q)
            && ptr_q == (($past(ptr_q) == STREAM_REG) ? $past(ptr_q) : 8'($past(ptr_q) + 8'h01));
    endproperty
    a_write_step: assert property (p_write_step) else $error("write store or step wrong"); // RL7

    property p_read_clear;
        (st_q == ST_ADDR && byte_done && addr_match && shift_q[0] && !preset_q)
            |=> ptr_q == IAS_PTR_RESET;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("plain read not at zero"); // RL10

    property p_read_preset;
        (st_q == ST_ADDR && byte_done && addr_match && shift_q[0] && preset_q)
            |=> ptr_q == $past(ptr_q);
    endproperty
    a_read_preset: assert property (p_read_preset) else $error("preset pointer lost"); // RL15

    property p_bit_valid;
        (st_q == ST_TX && ev.scl_rise) |-> sda_oe_q == !tx_q[7];
    endproperty
    a_bit_valid: assert property (p_bit_valid) else $error("data bit wrong at rising clock"); // RL11

    property p_read_step;
        (st_q == ST_TX && byte_done) |=> !sda_oe_q
            && ptr_q == (($past(ptr_q) == STREAM_REG) ? $past(ptr_q) : 8'($past(ptr_q) + 8'h01));
    endproperty
    a_read_step: assert property (p_read_step) else $error("read pointer step wrong"); // RL12

    property p_release;
        (st_q == ST_TACK) |-> !sda_oe_q;
    endproperty
    a_release: assert property (p_release) else $error("data driven in master ack slot"); // RL18

    property p_stop;
        ev.stop |=> st_q == ST_IDLE && !sda_oe_q && !preset_q;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not honoured"); // RL17

endmodule

`default_nettype wire

// ---- verification/ias_master_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module ias_master_model (
    // clock of the bench, paces the bus phases
    input wire logic clk,
    // bus lines
    output logic scl,
    output logic sda_low,
    input wire logic sda_line
);
    // phases far above the three-cycle minimum so the two-edge latency settles
    localparam int HALF = 8;
    localparam int QTR = 4;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    // data changes only while the clock line is low
    task automatic bit_io(input logic b, output logic r);
        wt(QTR);
        sda_low = !b;
        wt(HALF);
        scl = 1'b1;
        wt(HALF);
        r = sda_line;
        scl = 1'b0;
    endtask

    // also serves as repeated start; clock drops before any stop can follow
    task automatic start_c();
        wt(QTR);
        sda_low = 1'b0;
        wt(HALF);
        scl = 1'b1;
        wt(HALF);
        sda_low = 1'b1;
        wt(HALF);
        scl = 1'b0;
    endtask

    task automatic stop_c();
        wt(QTR);
        sda_low = 1'b1;
        wt(HALF);
        scl = 1'b1;
        wt(HALF);
        sda_low = 1'b0;
        wt(HALF);
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask

    // ack keeps the read going, nack on the last byte; rel is the slot level
    task automatic rd_byte(input logic last, output logic [7:0] d, output logic rel);
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(last, rel);
    endtask

    task automatic bits(input int n);
        logic r;
        for (int i = 0; i < n; i++) begin
            bit_io(1'b0, r);
        end
    endtask
endmodule

`default_nettype wire

// ---- verification/ias_slave_bench.sv ----
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end

module ias_slave_bench;
    import ias_pkg::*;

    logic clk;
    logic reset_n;
    logic scl;
    logic m_low;
    logic sda_line;
    logic sda_o;
    logic sda_oe;
    logic [7:0] reg_ptr;
    ias_reg_req_t reg_req;
    logic [7:0] reg_rd_data;
    logic [7:0] regs [256];
    logic [7:0] wq_a [$];
    logic [7:0] wq_d [$];
    logic [7:0] rq_a [$];
    logic [7:0] rq_d [$];
    logic [7:0] lf = 8'h16;
    int err_count = 0;
    int n_checks = 0;

    // pull-up on data: low when either side pulls
    assign sda_line = !(m_low | (sda_oe & !sda_o));
    assign reg_rd_data = regs[reg_ptr];

    ias_slave i_dut (.clk(clk), .reset_n(reset_n), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .reg_ptr(reg_ptr), .reg_req(reg_req),
        .reg_rd_data(reg_rd_data));

    ias_master_model m (.clk(clk), .scl(scl), .sda_low(m_low), .sda_line(sda_line));

    // register file stand-in; the stream port pops, so each read differs
    always @(posedge clk) begin
        if (reg_req.wr === 1'b1) begin
            regs[reg_req.addr] <= reg_req.data;
            wq_a.push_back(reg_req.addr);
            wq_d.push_back(reg_req.data);
        end
        if (reg_req.rd === 1'b1) begin
            rq_a.push_back(reg_req.addr);
            rq_d.push_back(reg_req.data);
            if (reg_req.addr == 8'h08) begin
                regs[8] <= regs[8] + 8'h01;
            end
        end
    end

    initial begin
        clk = 1'b0;
        forever #20 clk = !clk;
    end

    function automatic logic [7:0] rnd();
        lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
        return lf;
    endfunction

    function automatic logic [7:0] nxt(input logic [7:0] p);
        return (p == 8'h08) ? p : p + 8'h01;
    endfunction

    task automatic do_write(input logic [7:0] p, input int n);
        logic ack;
        logic [7:0] d;
        logic [7:0] e;
        logic [7:0] ga;
        logic [7:0] gd;
        e = p;
        m.start_c();
        m.wr_byte(8'hc4, ack);
        `CHK(ack, 1'b1);
        m.wr_byte(p, ack);
        `CHK(ack, 1'b1);
        for (int i = 0; i < n; i++) begin
            d = rnd();
            m.wr_byte(d, ack);
            `CHK(ack, 1'b1);
            // pop once here: the compare macro evaluates its arguments twice on a mismatch
            ga = (wq_a.size() > 0) ? wq_a.pop_front() : 8'hxx;
            gd = (wq_d.size() > 0) ? wq_d.pop_front() : 8'hxx;
            `CHK(ga, e);
            `CHK(gd, d);
            e = nxt(e);
        end
        `CHK(reg_ptr, e);
        m.stop_c();
    endtask

    task automatic do_read(input logic preset, input logic [7:0] p, input int n);
        logic ack;
        logic rel;
        logic [7:0] d;
        logic [7:0] e;
        logic [7:0] x;
        logic [7:0] ga;
        logic [7:0] gd;
        e = preset ? p : 8'h00;
        rq_a.delete();
        rq_d.delete();
        m.start_c();
        if (preset) begin
            m.wr_byte(8'hc4, ack);
            m.wr_byte(p, ack);
            m.start_c();
        end
        m.wr_byte(8'hc5, ack);
        `CHK(ack, 1'b1);
        for (int i = 0; i < n; i++) begin
            x = regs[e];
            m.rd_byte(i == n - 1, d, rel);
            ga = (rq_a.size() > 0) ? rq_a.pop_front() : 8'hxx;
            gd = (rq_d.size() > 0) ? rq_d.pop_front() : 8'hxx;
            `CHK(d, x);
            `CHK(ga, e);
            `CHK(gd, x);
            e = nxt(e);
        end
        `CHK(reg_ptr, e);
        `CHK(rel, 1'b1);
        m.stop_c();
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge clk);
        err_count++;
        results();
    end

    initial begin
        logic ack;
        logic [7:0] a;
        reset_n = 1'b0;
        for (int i = 0; i < 256; i++) begin
            regs[i] = rnd();
        end
        repeat (6) @(posedge clk);
        #2;
        reset_n = 1'b1;
        `CHK(reg_ptr, 8'h00);
        `CHK(sda_oe, 1'b0);
        m.wt(4);
        do_write(8'h16, 2);
        do_write(8'h08, 3);
        do_write(8'hff, 2);
        $display("writes done");
        do_read(1'b1, 8'h08, 3);
        do_read(1'b1, 8'h06, 4);
        do_read(1'b0, 8'h00, 2);
        $display("reads done");
        for (int i = 0; i < 4; i++) begin
            a = (i == 0) ? 8'hc6 : rnd();
            if (a[7:1] == 7'h62) begin
                a = 8'h00;
            end
            m.start_c();
            m.wr_byte({a[7:1], 1'b0}, ack);
            `CHK(ack, 1'b0);
            m.wr_byte(rnd(), ack);
            `CHK(ack, 1'b0);
            m.stop_c();
            `CHK(wq_a.size(), 0);
        end
        $display("foreign address done");
        m.start_c();
        m.wr_byte(8'hc4, ack);
        m.wr_byte(8'h11, ack);
        m.bits(5);
        m.stop_c();
        `CHK(wq_a.size(), 0);
        do_read(1'b0, 8'h00, 1);
        $display("abort done");
        for (int i = 0; i < 6; i++) begin
            a = rnd();
            do_write(a, 1 + (i % 3));
            do_read(1'b1, a, 1 + (i % 3));
        end
        $display("random done");
        results();
    end
endmodule

`default_nettype wire
